//--- inc/cle_pkg.sv
package cle_pkg;

	// ----------------------------------------
	// command memory geometry
	// ----------------------------------------
	localparam int          CLE_MEM_BYTES  = 2048;
	localparam int          CLE_UNIT_BYTES = 32;
	localparam int          CLE_UNITS      = 64;
	localparam int          CLE_LW_W       = 9;
	localparam logic [8:0]  CLE_LW_INIT0   = 9'h000;
	localparam logic [8:0]  CLE_LW_INIT1   = 9'h001;
	localparam logic [8:0]  CLE_LW_ID_BASE = 9'h004;
	localparam logic [1:0]  CLE_ID_LAST    = 2'h3;
	localparam logic [8:0]  CLE_LW_FUNC    = 9'h001;

	// ----------------------------------------
	// initialization longword fields
	// ----------------------------------------
	localparam int          CLE_MODE_HI    = 31;
	localparam int          CLE_MODE_LO    = 30;
	localparam logic [1:0]  CLE_MODE_INIT  = 2'h0;
	localparam logic [1:0]  CLE_MODE_FIRST = 2'h1;
	localparam logic [1:0]  CLE_MODE_NEXT  = 2'h2;
	localparam logic [1:0]  CLE_MODE_VEC   = 2'h3;
	localparam int          CLE_DL_ADDR_HI = 21;
	localparam int          CLE_DL_PG_HI   = 29;
	localparam int          CLE_DL_PG_LO   = 22;
	localparam int          CLE_VEC_HI     = 15;

	// ----------------------------------------
	// link words: low half command, high half response
	// ----------------------------------------
	localparam int          CLE_CLINK_HI   = 11;
	localparam int          CLE_CLINK_LO   = 2;
	localparam int          CLE_RLINK_HI   = 27;
	localparam int          CLE_RLINK_LO   = 18;
	localparam int          CLE_LINK_IDX   = 8;
	localparam logic [1:0]  CLE_WE_LO      = 2'h1;
	localparam logic [1:0]  CLE_WE_HI      = 2'h2;
	localparam logic [1:0]  CLE_WE_ALL     = 2'h3;

	// ----------------------------------------
	// function longword fields
	// ----------------------------------------
	localparam int          CLE_FN_BUSY    = 20;
	localparam int          CLE_FN_LAST    = 21;
	localparam int          CLE_FN_CST_LO  = 24;

	typedef struct packed {
		logic [21:0] addr;
		logic [8:0]  pages;
	} cle_dl_t;

	typedef struct packed {
		logic [8:0]  blk;
		logic [31:0] func;
	} cle_cmd_t;

	typedef struct packed {
		logic [8:0]  blk;
		logic [7:0]  status;
	} cle_done_t;

endpackage : cle_pkg

//--- tb/cle_engine_asserts.sv
`timescale 1ns/1ps
// --------------------------------
// engine port checker
// --------------------------------
module cle_engine_asserts
	import cle_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// window
	input wire logic        win_valid,
	input wire logic        win_ready,
	input wire logic        win_we,
	input wire logic        win_rvalid,
	// flags and events
	input wire logic        run_flag,
	input wire logic        irq_enable,
	input wire logic        responses_pending_set,
	input wire logic        list_end,
	input wire logic        irq_req,
	// download and channels
	input wire logic        dl_valid,
	input wire logic        dl_done,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire cle_cmd_t    cmd,
	input wire logic        done_valid,
	input wire logic        done_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_rd;
		win_valid && win_ready && !win_we |=> win_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer missing");
	property p_rdo;
		win_rvalid |-> $past(win_valid && win_ready && !win_we);
	endproperty
	a_rdo: assert property (p_rdo) else $error("read answer without read");
	property p_cmd;
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command dropped");
	property p_dl;
		dl_valid && !dl_done |=> dl_valid;
	endproperty
	a_dl: assert property (p_dl) else $error("download stage dropped");
	property p_early;
		$rose(run_flag) |-> !dl_valid && !irq_req ##1 !dl_valid && !irq_req;
	endproperty
	a_early: assert property (p_early) else $error("answer before block read");
	property p_end;
		list_end |-> responses_pending_set;
	endproperty
	a_end: assert property (p_end) else $error("list end without response");
	property p_rsp;
		done_valid && done_ready |-> ##[4:5] responses_pending_set;
	endproperty
	a_rsp: assert property (p_rsp) else $error("response not linked");
	property p_irq;
		responses_pending_set && irq_enable |-> irq_req;
	endproperty
	a_irq: assert property (p_irq) else $error("response interrupt missing");
	property p_id;
		$rose(rst_n) |-> !win_ready [*3];
	endproperty
	a_id: assert property (p_id) else $error("window open during id write");
	c_cmd: cover property (cmd_valid && cmd_ready);
	c_end: cover property (list_end);
	c_dl: cover property ($rose(dl_valid));
endmodule : cle_engine_asserts

bind cle_engine cle_engine_asserts i_chk (.clk(clk), .rst_n(rst_n), .win_valid(win_valid),
	.win_ready(win_ready), .win_we(win_we), .win_rvalid(win_rvalid), .run_flag(run_flag),
	.irq_enable(irq_enable), .responses_pending_set(responses_pending_set),
	.list_end(list_end), .irq_req(irq_req), .dl_valid(dl_valid), .dl_done(dl_done),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .done_valid(done_valid),
	.done_ready(done_ready));

//--- tb/cle_host.sv
`timescale 1ns/1ps
// --------------------------------
// host side of pointer and window
// --------------------------------
module cle_host (
	// clock
	input wire logic         clk,
	// pointer and window
	output logic             ptr_wr,
	output logic      [15:0] ptr_wdata,
	output logic             win_valid,
	output logic             win_we,
	output logic             win_hi,
	output logic      [15:0] win_wdata,
	input wire logic         win_ready,
	input wire logic         win_rvalid,
	input wire logic  [15:0] win_rdata
);
	initial begin
		ptr_wr = 1'b0;
		ptr_wdata = 16'h0000;
		win_valid = 1'b0;
		win_we = 1'b0;
		win_hi = 1'b0;
		win_wdata = 16'h0000;
	end
	task automatic setp(input logic [8:0] i);
		@(posedge clk);
		ptr_wr    <= 1'b1;
		ptr_wdata <= {5'h00, i, 2'h0};
		@(posedge clk);
		ptr_wr    <= 1'b0;
	endtask : setp
	// request held until the edge that sees ready
	task automatic req(input logic we, input logic hi, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		win_valid <= 1'b1;
		win_we    <= we;
		win_hi    <= hi;
		win_wdata <= d;
		do begin
			@(negedge clk);
			n++;
			if (n > 40) testbench.tmo();
		end while (win_ready !== 1'b1);
		@(posedge clk);
		win_valid <= 1'b0;
		win_wdata <= ~d; // released data never repeats
	endtask : req
	task automatic wr(input logic [8:0] i, input logic [31:0] v);
		setp(i);
		req(1'b1, 1'b0, v[15:0]);
		req(1'b1, 1'b1, v[31:16]);
	endtask : wr
	task automatic rd(input logic [8:0] i, output logic [31:0] v);
		setp(i);
		req(1'b0, 1'b0, 16'h0000);
		@(negedge clk);
		v[15:0] = win_rvalid ? win_rdata : 16'hxxxx;
		req(1'b0, 1'b1, 16'h0000);
		@(negedge clk);
		v[31:16] = win_rvalid ? win_rdata : 16'hxxxx;
	endtask : rd
endmodule : cle_host

//--- tb/testbench.sv
`timescale 1ns/1ps
// --------------------------------
// bench top
// --------------------------------
module testbench;
	import cle_pkg::*;
	// arbitrary id pattern, distinct words so a misplaced word shows
	localparam logic [127:0] NID = 128'h7e81_d24b_c3a5_0f1e_2d3c_4b5a_3c5a_96e1;
	logic        clk, rst_n, ptr_wr, win_valid, win_ready, win_we, win_hi, win_rvalid;
	logic [15:0] ptr_wdata, win_wdata, win_rdata, irq_vector;
	logic        run_flag, list_valid_flag, commands_pending_flag, irq_enable;
	logic        commands_pending_clr, responses_pending_set, list_end, irq_req;
	logic        dl_valid, dl_done, cmd_valid, cmd_ready, done_valid, done_ready;
	cle_dl_t     dl_req;
	cle_cmd_t    cmd;
	cle_done_t   done;
	logic [31:0] v;
	int          fail_count, n_tests, n_clr;
	cle_engine #(.MEM_LW(512), .NET_ID(NID)) i_dut (.clk(clk), .rst_n(rst_n),
		.ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .win_valid(win_valid), .win_ready(win_ready),
		.win_we(win_we), .win_hi(win_hi), .win_wdata(win_wdata), .win_rvalid(win_rvalid),
		.win_rdata(win_rdata), .run_flag(run_flag), .list_valid_flag(list_valid_flag),
		.commands_pending_flag(commands_pending_flag), .irq_enable(irq_enable),
		.commands_pending_clr(commands_pending_clr),
		.responses_pending_set(responses_pending_set), .list_end(list_end),
		.irq_req(irq_req), .irq_vector(irq_vector), .dl_valid(dl_valid), .dl_req(dl_req),
		.dl_done(dl_done), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.done_valid(done_valid), .done_ready(done_ready), .done(done));
	cle_host i_host (.clk(clk), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .win_valid(win_valid),
		.win_we(win_we), .win_hi(win_hi), .win_wdata(win_wdata), .win_ready(win_ready),
		.win_rvalid(win_rvalid), .win_rdata(win_rdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// pulse may land during a handshake, so count it
	always @(posedge clk) if (commands_pending_clr === 1'b1) n_clr <= n_clr + 1;
	// --------------------------------
	// checking and closing
	// --------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task tmo;
		fail_count++;
		stop_test();
	endtask : tmo
	function automatic logic sel(input int k);
		case (k)
			0: return cmd_valid;
			1: return dl_valid;
			2: return responses_pending_set;
			3: return irq_req;
			default: return done_ready;
		endcase
	endfunction : sel
	task automatic wt(input int k);
		int n;
		n = 0;
		@(negedge clk);
		while (sel(k) !== 1'b1) begin
			n++;
			if (n > 60) tmo();
			@(negedge clk);
		end
	endtask : wt
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic start(input logic [31:0] lw0, input logic [31:0] lw1);
		@(posedge clk);
		run_flag <= 1'b0;
		i_host.wr(9'h000, lw0);
		i_host.wr(9'h001, lw1);
		@(posedge clk);
		run_flag <= 1'b1;
	endtask : start
	task automatic t_id;
		for (int i = 4; i < 8; i++) begin
			i_host.rd(9'(i), v);
			chk(v, NID[32*(i-4) +: 32]);
		end
	endtask : t_id
	task automatic t_vec;
		start(32'h0000_0000, 32'hc000_5a5a);
		wt(3);
		chk(32'(irq_vector), 32'h5a5a);
		chk(32'(dl_valid), 32'h0);
	endtask : t_vec
	task automatic t_dl(input logic [31:0] lw1, input logic [21:0] a, input logic [8:0] p);
		start(32'h0000_0000, lw1);
		wt(1);
		chk(32'(dl_req.addr), 32'(a));
		chk(32'(dl_req.pages), 32'(p));
		@(posedge clk);
		dl_done <= 1'b1;
		@(posedge clk);
		dl_done <= 1'b0;
		@(negedge clk);
		chk(32'(dl_valid), 32'h0);
		chk(32'(irq_req), 32'h1);
		chk(32'(irq_vector), 32'h5a5a);
	endtask : t_dl
	task automatic take(input logic [8:0] b, input logic [31:0] f);
		wt(0);
		chk(32'(cmd.blk), 32'(b));
		chk(cmd.func, f);
		@(posedge clk);
		cmd_ready <= 1'b1;
		@(posedge clk);
		cmd_ready <= 1'b0;
	endtask : take
	task automatic fin(input logic [8:0] b, input logic [7:0] s, input logic ie, input logic l);
		@(posedge clk);
		irq_enable <= ie;
		done_valid <= 1'b1;
		done       <= '{blk: b, status: s};
		wt(4);
		@(posedge clk);
		done_valid <= 1'b0;
		wt(2);
		chk(32'(list_end), 32'(l));
		chk(32'(irq_req), 32'(ie));
		if (ie) chk(32'(irq_vector), 32'h00a0);
	endtask : fin
	task automatic t_list;
		i_host.wr(9'h008, 32'h0000_0050);
		i_host.wr(9'h009, 32'h0000_0010);
		i_host.wr(9'h014, 32'h0000_0000);
		i_host.wr(9'h015, 32'h0000_0120);
		@(posedge clk);
		list_valid_flag       <= 1'b1;
		commands_pending_flag <= 1'b1;
		start(32'h0000_0020, 32'h0000_00a0);
		take(9'h008, 32'h0000_0010);
		chk(32'(n_clr), 32'h0);
		take(9'h014, 32'h0000_0120);
		fin(9'h008, 8'h01, 1'b1, 1'b0);
		chk(32'(n_clr), 32'h1);
		@(posedge clk);
		commands_pending_flag <= 1'b0;
		fin(9'h014, 8'h02, 1'b0, 1'b1);
		i_host.rd(9'h009, v);
		chk(v, 32'h0110_0010);
		i_host.rd(9'h015, v);
		chk(v, 32'h0230_0120);
		i_host.rd(9'h008, v);
		chk(v, 32'h0050_0050);
		i_host.rd(9'h014, v);
		chk(v, 32'h0000_0000);
	endtask : t_list
	task automatic t_relist;
		i_host.wr(9'h018, 32'h0000_0000);
		i_host.wr(9'h019, 32'h0000_0011);
		i_host.wr(9'h000, 32'h0000_0060);
		@(posedge clk);
		list_valid_flag       <= 1'b0;
		@(posedge clk);
		list_valid_flag       <= 1'b1;
		commands_pending_flag <= 1'b1;
		take(9'h018, 32'h0000_0011);
	endtask : t_relist
	initial begin
		rst_n = 1'b0;
		run_flag = 1'b0;
		list_valid_flag = 1'b0;
		commands_pending_flag = 1'b0;
		irq_enable = 1'b1;
		dl_done = 1'b0;
		cmd_ready = 1'b0;
		done_valid = 1'b0;
		done = '0;
		fail_count = 0;
		n_tests = 0;
		n_clr = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_id();
		t_vec();
		t_dl(32'h40c1_2345, 22'h012345, 9'h004);
		t_dl(32'hbfff_ffff, 22'h3fffff, 9'h100);
		t_list();
		t_relist();
		stop_test();
	end
endmodule : testbench

//--- verilog/cle_cmd_mem.sv
`timescale 1ns/1ps
module cle_cmd_mem #(
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// access port
	input  wire logic          en,
	input  wire logic [1:0]    we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [31:0]   wdata,
	output logic      [31:0]   rdata
);

	initial begin
		if (DEPTH > (1 << AW) || DEPTH < 2) begin
			$error("cle_cmd_mem: depth does not fit address width");
		end
	end

	logic [31:0] mem [DEPTH];

	// ----------------------------------------
	// half-word writes, registered read
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (en && we[0]) begin
			mem[addr][15:0] <= wdata[15:0];
		end
		if (en && we[1]) begin
			mem[addr][31:16] <= wdata[31:16];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (en) begin
			rdata <= mem[addr];
		end
	end

endmodule : cle_cmd_mem

//--- verilog/cle_engine.sv
`timescale 1ns/1ps
// Function
// - on run, load vector and list state from initialization block.
// - top two bits of second longword: both softload vector, neither initialize.
// - interrupt through softload vector after each softload stage.
// - bit 30 alone: first download block address and page count minus one.
// - bit 31 alone: next download block address and page count minus one.
// - first word is command list start; reread each time list valid sets; a set seen in ST_INIT0_USE is dropped.
// - non-zero start with run, pending, valid set: process list right away.
// - responses from initialization commands interrupt when interrupts enabled.
// - high half of first word is response list start, block or zero.
// - after self-test write network identification into words five to eight.
// - 32-byte blocks, single forward link, separate command and response chains.
// - issue commands concurrently, queue those that cannot start yet; here one waiting for cmd_ready holds the rest of the list back.
// - on completion or abort update block status, link onto response list.
// - respond until last block, mark it end of list; host relists.
// - only link bits 11 to 2 used, low bits unforced, zero ends list.
// - write response link, zero if last, before responses pending set.
// - 2048-byte memory of 64 units, first the initialization block.
// - set bit 21 of function longword in last block's response.
module cle_engine
	import cle_pkg::*;
#(
	parameter int           MEM_LW = 512,
	// identification value is arbitrary
	parameter logic [127:0] NET_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// host pointer and data window
	input  wire logic        ptr_wr,
	input  wire logic [15:0] ptr_wdata,
	input  wire logic        win_valid,
	output logic             win_ready,
	input  wire logic        win_we,
	input  wire logic        win_hi,
	input  wire logic [15:0] win_wdata,
	output logic             win_rvalid,
	output logic      [15:0] win_rdata,
	// flags
	input  wire logic        run_flag,
	input  wire logic        list_valid_flag,
	input  wire logic        commands_pending_flag,
	input  wire logic        irq_enable,
	output logic             commands_pending_clr,
	output logic             responses_pending_set,
	output logic             list_end,
	// interrupt request
	output logic             irq_req,
	output logic      [15:0] irq_vector,
	// softload download
	output logic             dl_valid,
	output cle_dl_t          dl_req,
	input  wire logic        dl_done,
	// channel command issue and completion
	output logic             cmd_valid,
	input  wire logic        cmd_ready,
	output cle_cmd_t         cmd,
	input  wire logic        done_valid,
	output logic             done_ready,
	input  wire cle_done_t   done
);

	initial begin
		if (MEM_LW != CLE_MEM_BYTES / 4 || CLE_UNITS * CLE_UNIT_BYTES != CLE_MEM_BYTES) begin
			$error("cle_engine: command memory must hold 512 longwords");
		end
	end

	typedef enum logic [3:0] {
		ST_ID, ST_IDLE, ST_INIT1_USE, ST_INIT0_USE, ST_SL_DL, ST_RUN, ST_LIST_USE,
		ST_CMD0_USE, ST_CMD1_USE, ST_ISSUE, ST_FN_USE, ST_RSP_LINK, ST_RSP_TAIL, ST_RSP_FLAG
	} cle_state_t;

	cle_state_t    state;
	logic [1:0]    id_cnt;
	logic          run_q;
	logic          lv_q;
	logic          relist;
	logic          walking;
	logic [8:0]    walk_ptr;
	logic [8:0]    next_link;
	logic          last_ok;
	logic [8:0]    last_blk;
	logic [8:0]    resp_tail;
	logic [15:0]   sl_vec;
	logic [15:0]   int_vec;
	cle_done_t     done_q;
	logic [8:0]    host_ptr;
	logic          host_hi_q;
	logic          eng_en;
	logic [1:0]    eng_we;
	logic [8:0]    eng_addr;
	logic [31:0]   eng_wdata;
	logic          m_en;
	logic [1:0]    m_we;
	logic [8:0]    m_addr;
	logic [31:0]   m_wdata;
	logic [31:0]   m_rdata;
	logic          lv_rise;

	// link field (low unforced bits already dropped) to longword index, ignoring its top bit
	function automatic logic [8:0] link_idx(input logic [9:0] link);
		link_idx = link[CLE_LINK_IDX:0];
	endfunction : link_idx

	assign lv_rise = list_valid_flag && !lv_q;

	// ----------------------------------------
	// engine memory requests
	// ----------------------------------------
	always_comb begin
		eng_en    = 1'b0;
		eng_we    = 2'h0;
		eng_addr  = CLE_LW_INIT0;
		eng_wdata = 32'h0000_0000;
		case (state)
			ST_ID: begin
				eng_en    = 1'b1;
				eng_we    = CLE_WE_ALL;
				eng_addr  = CLE_LW_ID_BASE + 9'(id_cnt);
				eng_wdata = NET_ID[32*id_cnt +: 32];
			end
			ST_IDLE: begin
				eng_en   = run_flag && !run_q;
				eng_addr = CLE_LW_INIT1;
			end
			ST_INIT1_USE: begin
				eng_en   = m_rdata[CLE_MODE_HI:CLE_MODE_LO] == CLE_MODE_INIT;
				eng_addr = CLE_LW_INIT0;
			end
			ST_RUN: begin
				if (!run_flag) begin
					eng_en = 1'b0;
				end else if (done_valid) begin
					eng_en   = 1'b1;
					eng_addr = done.blk + CLE_LW_FUNC;
				end else if (relist) begin
					eng_en   = 1'b1;
					eng_addr = CLE_LW_INIT0;
				end else if (walking && commands_pending_flag) begin
					eng_en   = 1'b1;
					eng_addr = walk_ptr;
				end
			end
			ST_CMD0_USE: begin
				eng_en   = 1'b1;
				eng_addr = walk_ptr + CLE_LW_FUNC;
			end
			ST_FN_USE: begin
				eng_en    = 1'b1;
				eng_we    = CLE_WE_ALL;
				eng_addr  = done_q.blk + CLE_LW_FUNC;
				eng_wdata = m_rdata;
				eng_wdata[31:CLE_FN_CST_LO] = done_q.status;
				eng_wdata[CLE_FN_BUSY]      = 1'b1;
				eng_wdata[CLE_FN_LAST]      = last_ok && last_blk == done_q.blk;
			end
			ST_RSP_LINK: begin
				eng_en   = 1'b1;
				eng_we   = CLE_WE_HI;
				eng_addr = done_q.blk;
			end
			ST_RSP_TAIL: begin
				eng_en    = 1'b1;
				eng_we    = CLE_WE_HI;
				eng_addr  = resp_tail;
				eng_wdata = {5'h00, done_q.blk, 2'h0, 16'h0000};
			end
			default: begin
				eng_en = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// memory arbitration, engine first
	// ----------------------------------------
	assign win_ready = !eng_en;
	assign m_en      = eng_en || win_valid;
	assign m_we      = eng_en ? eng_we : (win_we ? (win_hi ? CLE_WE_HI : CLE_WE_LO) : 2'h0);
	assign m_addr    = eng_en ? eng_addr : host_ptr;
	assign m_wdata   = eng_en ? eng_wdata : {win_wdata, win_wdata};
	assign win_rdata = host_hi_q ? m_rdata[31:16] : m_rdata[15:0];

	cle_cmd_mem #(
		.DEPTH (MEM_LW),
		.AW    (CLE_LW_W)
	) u_mem (
		.clk   (clk),
		.rst_n (rst_n),
		.en    (m_en),
		.we    (m_we),
		.addr  (m_addr),
		.wdata (m_wdata),
		.rdata (m_rdata)
	);

	// ----------------------------------------
	// host pointer and window
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			host_ptr <= 9'h000;
		end else if (ptr_wr) begin
			host_ptr <= ptr_wdata[10:2];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			win_rvalid <= 1'b0;
			host_hi_q  <= 1'b0;
		end else begin
			win_rvalid <= win_valid && win_ready && !win_we;
			if (win_valid && win_ready) begin
				host_hi_q <= win_hi;
			end
		end
	end

	// ----------------------------------------
	// flag edges
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			lv_q  <= 1'b0;
		end else begin
			run_q <= run_flag;
			lv_q  <= list_valid_flag;
		end
	end

	// a set seen while busy waits here; a new set beats the clear, except in ST_INIT0_USE where it is dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			relist <= 1'b0;
		end else if (lv_rise && state != ST_INIT0_USE) begin
			relist <= 1'b1;
		end else if (state == ST_LIST_USE || state == ST_INIT0_USE || state == ST_IDLE) begin
			relist <= 1'b0;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state                 <= ST_ID;
			id_cnt                <= 2'h0;
			walking               <= 1'b0;
			walk_ptr              <= 9'h000;
			next_link             <= 9'h000;
			last_ok               <= 1'b0;
			last_blk              <= 9'h000;
			resp_tail             <= 9'h000;
			sl_vec                <= 16'h0000;
			int_vec               <= 16'h0000;
			done_q                <= '0;
			dl_req                <= '0;
			cmd                   <= '0;
			irq_req               <= 1'b0;
			irq_vector            <= 16'h0000;
			commands_pending_clr  <= 1'b0;
			responses_pending_set <= 1'b0;
			list_end              <= 1'b0;
		end else begin
			irq_req               <= 1'b0;
			commands_pending_clr  <= 1'b0;
			responses_pending_set <= 1'b0;
			list_end              <= 1'b0;
			case (state)
				ST_ID: begin
					id_cnt <= id_cnt + 2'h1;
					if (id_cnt == CLE_ID_LAST) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					walking <= 1'b0;
					last_ok <= 1'b0;
					if (run_flag && !run_q) begin
						state <= ST_INIT1_USE;
					end
				end
				ST_INIT1_USE: begin
					case (m_rdata[CLE_MODE_HI:CLE_MODE_LO])
						CLE_MODE_VEC: begin
							sl_vec     <= m_rdata[CLE_VEC_HI:0];
							irq_req    <= 1'b1;
							irq_vector <= m_rdata[CLE_VEC_HI:0];
							state      <= ST_IDLE;
						end
						CLE_MODE_FIRST, CLE_MODE_NEXT: begin
							dl_req.addr  <= m_rdata[CLE_DL_ADDR_HI:0];
							dl_req.pages <= {1'b0, m_rdata[CLE_DL_PG_HI:CLE_DL_PG_LO]} + 9'h001;
							state        <= ST_SL_DL;
						end
						default: begin
							int_vec <= m_rdata[CLE_VEC_HI:0];
							state   <= ST_INIT0_USE;
						end
					endcase
				end
				ST_SL_DL: begin
					if (dl_done) begin
						irq_req    <= 1'b1;
						irq_vector <= sl_vec;
						state      <= ST_IDLE;
					end
				end
				ST_INIT0_USE: begin
					resp_tail <= link_idx(m_rdata[CLE_RLINK_HI:CLE_RLINK_LO]);
					walk_ptr  <= link_idx(m_rdata[CLE_CLINK_HI:CLE_CLINK_LO]);
					walking   <= m_rdata[CLE_CLINK_HI:CLE_CLINK_LO] != 10'h000
						&& list_valid_flag && commands_pending_flag;
					state     <= ST_RUN;
				end
				ST_RUN: begin
					if (!run_flag) begin
						state <= ST_IDLE;
					end else if (done_valid) begin
						done_q <= done;
						state  <= ST_FN_USE;
					end else if (relist) begin
						state <= ST_LIST_USE;
					end else if (walking && commands_pending_flag) begin
						state <= ST_CMD0_USE;
					end
				end
				ST_LIST_USE: begin
					walk_ptr <= link_idx(m_rdata[CLE_CLINK_HI:CLE_CLINK_LO]);
					walking  <= m_rdata[CLE_CLINK_HI:CLE_CLINK_LO] != 10'h000;
					last_ok  <= 1'b0;
					state    <= ST_RUN;
				end
				ST_CMD0_USE: begin
					next_link <= link_idx(m_rdata[CLE_CLINK_HI:CLE_CLINK_LO]);
					last_ok   <= m_rdata[CLE_CLINK_HI:CLE_CLINK_LO] == 10'h000;
					state     <= ST_CMD1_USE;
				end
				ST_CMD1_USE: begin
					cmd.blk  <= walk_ptr;
					cmd.func <= m_rdata;
					state    <= ST_ISSUE;
				end
				ST_ISSUE: begin
					// waiting for channel space holds the rest of the list back
					if (cmd_ready) begin
						if (last_ok) begin
							last_blk             <= walk_ptr;
							walking              <= 1'b0;
							commands_pending_clr <= 1'b1;
						end else begin
							walk_ptr <= next_link;
						end
						state <= ST_RUN;
					end
				end
				ST_FN_USE: begin
					state <= ST_RSP_LINK;
				end
				ST_RSP_LINK: begin
					state <= resp_tail != 9'h000 ? ST_RSP_TAIL : ST_RSP_FLAG;
					if (resp_tail == 9'h000) begin
						resp_tail <= done_q.blk;
					end
				end
				ST_RSP_TAIL: begin
					resp_tail <= done_q.blk;
					state     <= ST_RSP_FLAG;
				end
				ST_RSP_FLAG: begin
					responses_pending_set <= 1'b1;
					list_end              <= last_ok && !walking && last_blk == done_q.blk;
					irq_req               <= irq_enable;
					irq_vector            <= int_vec;
					state                 <= ST_RUN;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign dl_valid   = state == ST_SL_DL;
	assign cmd_valid  = state == ST_ISSUE;
	assign done_ready = state == ST_RUN && run_flag;

endmodule : cle_engine
